// *** src/sebfe_consts.vh ***
// Constants for the two-wire bus front end of the serial memory
`ifndef SEBFE_CONSTS_VH
`define SEBFE_CONSTS_VH

// System clock rate in Hz
`define SEBFE_CLOCK_HZ 25000000
// Internal write cycle, longest time in ms
`define SEBFE_INTERNAL_WRITE_TIME_MS 5
// Cycles of the internal write cycle, rounded down
`define SEBFE_WRITE_CYCLES (`SEBFE_INTERNAL_WRITE_TIME_MS * (`SEBFE_CLOCK_HZ / 1000))

// Upper nibble of the device address word
`define SEBFE_SEL_ARRAY 4'hA
`define SEBFE_SEL_SERIAL 4'hB
// Required pattern in first word address bits 3..2 for serial access
`define SEBFE_SN_WA1_PAT 2'h2
// Data returned when the serial area is addressed wrongly
`define SEBFE_SN_BAD_DATA 8'hFF
// Data of the upper half of the 32-byte serial area
`define SEBFE_SN_PAD_DATA 8'h00

// Role of the byte being received
`define SEBFE_KIND_DEV 2'h0
`define SEBFE_KIND_WA1 2'h1
`define SEBFE_KIND_WA2 2'h2
`define SEBFE_KIND_DATA 2'h3

// Bits in a word, and reset values
`define SEBFE_BITS_PER_WORD 4'h8
`define SEBFE_PTR_RESET 12'h000

`endif

// *** src/sebfe_target.v ***
// Two-wire bus target front end with serial number area and write cycle timer
// Functional notes
// - Data changes only while clock low
// - Falling data with clock high is start
// - Rising data with clock high is stop
// - Eight-bit words MSB first, ninth-clock acknowledge
// - Standby after reset, after a stop with no write, and after the write cycle
// - First byte upper nibble 1010 selects array
// - Address bits three to one match straps
// - Lowest address bit selects read or write
// - Mismatch gives no acknowledge, back to standby
// - Upper nibble 1011 selects serial number area
// - Serial access reads; write only loads pointer
// - Serial number area never written
// - First word address holds bits eleven to eight
// - Second word address holds bits seven to zero
// - Write cycle starts at stop, lasts 5 ms
// - Bus ignored during internal write cycle
// - Sample on clock rise, launch after fall
// - Write protect blocks writes, reads still work
// - Page write advances only low five bits
`timescale 1ns/1ns
`include "sebfe_consts.vh"

module sebfe_target #(
	parameter WRITE_CYCLES = `SEBFE_WRITE_CYCLES,
	parameter [127:0] SERIAL_NUMBER = 128'h0123456789ABCDEF0123456789ABCDEF // Arbitrary value
)(
	input wire clock,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	input wire strap_addr_bit2,
	input wire strap_addr_bit1,
	input wire strap_addr_bit0,
	input wire write_protect,
	output wire [11:0] rd_addr,
	input wire [7:0] rd_data,
	output wire wr_valid,
	input wire wr_ready,
	output wire [11:0] wr_addr,
	output wire [7:0] wr_data,
	output wire busy,
	output wire standby
);

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_RX = 5'h02;
	localparam [4:0] ST_ACK = 5'h04;
	localparam [4:0] ST_TX = 5'h08;
	localparam [4:0] ST_MACK = 5'h10;

	reg scl_s1_reg, scl_s2_reg, scl_d_reg;
	reg sda_s1_reg, sda_s2_reg, sda_d_reg;
	reg [3:0] pins_s1_reg, pins_s2_reg;
	reg [4:0] state_reg;
	reg [1:0] kind_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg [11:0] ptr_reg;
	reg rw_reg;
	reg sn_sel_reg;
	reg sn_bad_reg;
	reg wrote_reg;
	reg mack_reg;
	reg oe_n_reg;
	reg sda_out_reg;
	reg busy_reg;
	reg standby_reg;
	reg [16:0] wcnt_reg;
	reg head_v_reg;
	reg [19:0] head_reg;
	reg spare_v_reg;
	reg [19:0] spare_reg;
	reg ack_ok;
	reg push;
	reg [7:0] tx_byte;
	wire scl_rise, scl_fall, bus_start, bus_stop, pop, in_ready;
	wire [2:0] strap_s;
	wire wp_s;
	wire [6:0] sn_base;
	wire [16:0] wcnt_last;
	wire [31:0] wcycles_full;

	// Next pointer: page mode keeps the upper bits and wraps the low five
	function [11:0] next_ptr;
		input [11:0] p;
		input page;
		begin
			if (page)
				next_ptr = {p[11:5], p[4:0] + 5'h01};
			else
				next_ptr = p + 12'h001;
		end
	endfunction

	// Two flops on every pin before any logic reads it
	always @(posedge clock)
	begin
		if (rst)
		begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			pins_s1_reg <= 4'h0;
			pins_s2_reg <= 4'h0;
		end
		else
		begin
			scl_s1_reg <= scl_in;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg <= scl_s2_reg;
			sda_s1_reg <= sda_in;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg <= sda_s2_reg;
			pins_s1_reg <= {write_protect, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
			pins_s2_reg <= pins_s1_reg;
		end
	end

	// Edges from the synchronised lines; both lines share the same delay
	assign scl_rise = scl_s2_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s2_reg & scl_d_reg;
	assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
	assign strap_s = pins_s2_reg[2:0];
	assign wp_s = pins_s2_reg[3];
	assign sn_base = 7'h7F - {ptr_reg[3:0], 3'h0};
	// Cycle count fits 17 bits for a 5 ms cycle at 25 MHz; wider values would truncate
	assign wcycles_full = WRITE_CYCLES;
	assign wcnt_last = wcycles_full[16:0] - 17'h00001;

	// Acknowledge decision for the byte just received
	always @*
	begin
		ack_ok = 1'b0;
		push = 1'b0;
		case (kind_reg)
			`SEBFE_KIND_DEV:
				ack_ok = ((shift_reg[7:4] == `SEBFE_SEL_ARRAY)
					|| (shift_reg[7:4] == `SEBFE_SEL_SERIAL))
					&& (shift_reg[3:1] == strap_s);
			`SEBFE_KIND_DATA:
			begin
				// Serial area and protected array take the byte but never store it
				push = !sn_sel_reg && !wp_s && in_ready;
				ack_ok = sn_sel_reg || wp_s || in_ready;
			end
			default:
				ack_ok = 1'b1;
		endcase
		if (!(state_reg == ST_RX && scl_fall && bit_cnt_reg == `SEBFE_BITS_PER_WORD))
			push = 1'b0;
	end

	// Byte to send: serial area from the fixed number, array from outside
	always @*
	begin
		if (!sn_sel_reg)
			tx_byte = rd_data;
		else if (sn_bad_reg)
			tx_byte = `SEBFE_SN_BAD_DATA;
		else if (ptr_reg[4])
			tx_byte = `SEBFE_SN_PAD_DATA;
		else
			tx_byte = SERIAL_NUMBER[sn_base -: 8];
	end

	// Bus protocol engine and write cycle timer
	always @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			kind_reg <= `SEBFE_KIND_DEV;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= `SEBFE_PTR_RESET;
			rw_reg <= 1'b0;
			sn_sel_reg <= 1'b0;
			sn_bad_reg <= 1'b0;
			wrote_reg <= 1'b0;
			mack_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			sda_out_reg <= 1'b0;
			busy_reg <= 1'b0;
			standby_reg <= 1'b1;
			wcnt_reg <= 17'h00000;
		end
		else if (busy_reg)
		begin
			// Inputs are shut out until the write cycle ends
			state_reg <= ST_IDLE;
			oe_n_reg <= 1'b1;
			wcnt_reg <= wcnt_reg + 17'h00001;
			if (wcnt_reg == wcnt_last)
			begin
				busy_reg <= 1'b0;
				standby_reg <= 1'b1;
			end
		end
		else if (bus_start)
		begin
			// A start restarts except during the write cycle, which also ends a recovery sequence
			state_reg <= ST_RX;
			kind_reg <= `SEBFE_KIND_DEV;
			bit_cnt_reg <= 4'h0;
			oe_n_reg <= 1'b1;
			wrote_reg <= 1'b0;
			standby_reg <= 1'b0;
		end
		else if (bus_stop)
		begin
			state_reg <= ST_IDLE;
			oe_n_reg <= 1'b1;
			wrote_reg <= 1'b0;
			if (wrote_reg)
			begin
				busy_reg <= 1'b1;
				standby_reg <= 1'b0;
				wcnt_reg <= 17'h00000;
			end
			else
				standby_reg <= 1'b1;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
					oe_n_reg <= 1'b1;
				ST_RX:
				begin
					if (scl_rise && bit_cnt_reg != `SEBFE_BITS_PER_WORD)
					begin
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					if (scl_fall && bit_cnt_reg == `SEBFE_BITS_PER_WORD)
					begin
						if (ack_ok)
						begin
							oe_n_reg <= 1'b0;
							state_reg <= ST_ACK;
						end
						else
						begin
							state_reg <= ST_IDLE;
							standby_reg <= 1'b1;
						end
						case (kind_reg)
							`SEBFE_KIND_DEV:
							begin
								rw_reg <= shift_reg[0];
								sn_sel_reg <= shift_reg[4];
								kind_reg <= `SEBFE_KIND_WA1;
							end
							`SEBFE_KIND_WA1:
							begin
								ptr_reg[11:8] <= shift_reg[3:0];
								sn_bad_reg <= sn_sel_reg
									&& (shift_reg[3:2] != `SEBFE_SN_WA1_PAT);
								kind_reg <= `SEBFE_KIND_WA2;
							end
							`SEBFE_KIND_WA2:
							begin
								ptr_reg[7:0] <= shift_reg;
								kind_reg <= `SEBFE_KIND_DATA;
							end
							default:
							begin
								if (push)
								begin
									ptr_reg <= next_ptr(ptr_reg, 1'b1);
									wrote_reg <= 1'b1;
								end
							end
						endcase
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						bit_cnt_reg <= 4'h0;
						if (kind_reg == `SEBFE_KIND_WA1 && rw_reg)
						begin
							// Read: launch first bit after the ninth clock falls
							shift_reg <= tx_byte;
							oe_n_reg <= tx_byte[7];
							ptr_reg <= next_ptr(ptr_reg, sn_sel_reg);
							state_reg <= ST_TX;
						end
						else
						begin
							oe_n_reg <= 1'b1;
							state_reg <= ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (scl_rise)
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (scl_fall)
					begin
						if (bit_cnt_reg == `SEBFE_BITS_PER_WORD)
						begin
							oe_n_reg <= 1'b1;
							state_reg <= ST_MACK;
						end
						else
						begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							oe_n_reg <= shift_reg[6];
						end
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
						mack_reg <= ~sda_s2_reg;
					if (scl_fall)
					begin
						bit_cnt_reg <= 4'h0;
						if (mack_reg)
						begin
							shift_reg <= tx_byte;
							oe_n_reg <= tx_byte[7];
							ptr_reg <= next_ptr(ptr_reg, sn_sel_reg);
							state_reg <= ST_TX;
						end
						else
							state_reg <= ST_IDLE;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Two-entry write buffer; a full buffer makes the engine withhold its acknowledge
	assign in_ready = !spare_v_reg;
	assign pop = head_v_reg && wr_ready;

	always @(posedge clock)
	begin
		if (rst)
		begin
			head_v_reg <= 1'b0;
			head_reg <= 20'h00000;
			spare_v_reg <= 1'b0;
			spare_reg <= 20'h00000;
		end
		else if (!head_v_reg || pop)
		begin
			if (spare_v_reg)
			begin
				head_reg <= spare_reg;
				head_v_reg <= 1'b1;
				spare_v_reg <= push;
				if (push)
					spare_reg <= {ptr_reg, shift_reg};
			end
			else
			begin
				head_v_reg <= push;
				if (push)
					head_reg <= {ptr_reg, shift_reg};
			end
		end
		else if (push)
		begin
			spare_reg <= {ptr_reg, shift_reg};
			spare_v_reg <= 1'b1;
		end
	end

	// Outputs straight from flops; the pin is open drain, pulled low only
	assign sda_out = sda_out_reg;
	assign sda_oe_n = oe_n_reg;
	assign rd_addr = ptr_reg;
	assign wr_valid = head_v_reg;
	assign wr_addr = head_reg[19:8];
	assign wr_data = head_reg[7:0];
	assign busy = busy_reg;
	assign standby = standby_reg;

endmodule

// *** bench/sebfe_chk.sv ***
// Checker of the port behaviour of the two-wire bus target front end
`timescale 1ns/1ns
module sebfe_chk #(
	parameter int WRITE_CYCLES = 200
)(
	input wire clock,
	input wire rst,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire write_protect,
	input wire wr_valid,
	input wire wr_ready,
	input wire [11:0] wr_addr,
	input wire [7:0] wr_data,
	input wire busy,
	input wire standby
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	int unsigned busy_cnt_reg;
	// Length of the current write cycle, cleared whenever it is not running
	always @(posedge clock)
		if (rst || !busy)
			busy_cnt_reg <= 0;
		else
			busy_cnt_reg <= busy_cnt_reg + 1;
	// A stalled head word must not move or change
	sequence word_held;
		wr_valid && $stable(wr_addr) && $stable(wr_data);
	endsequence
	reset_state_a: assert property (disable iff (1'b0) rst |=> sda_oe_n && !busy && standby && !wr_valid) else $error("state after reset");
	drive_low_a: assert property (!sda_oe_n |-> !sda_out) else $error("data pin driven high");
	ack_whole_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*6]) else $error("driven bit too short");
	launch_low_a: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("data changed while clock high");
	busy_quiet_a: assert property (busy |-> sda_oe_n) else $error("answer during write cycle");
	busy_standby_a: assert property (busy |-> !standby) else $error("standby during write cycle");
	busy_len_a: assert property ($fell(busy) |-> busy_cnt_reg == WRITE_CYCLES) else $error("write cycle length");
	head_hold_a: assert property (wr_valid && !wr_ready |=> word_held) else $error("stalled word lost");
	wp_block_a: assert property ($rose(wr_valid) |-> !$past(write_protect, 3)) else $error("write while protected");
endmodule

bind sebfe_target sebfe_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clock(clock), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
	.busy(busy), .standby(standby));

// *** bench/sebfe_host.sv ***
// Bus master model that drives the bus clock and data lines
`timescale 1ns/1ns
module sebfe_host (
	input wire clock,
	input wire sda_line,
	output logic scl,
	output logic sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Six clocks low, two high: 320 ns, data moved mid low phase
	task automatic bit_io(input logic b, output logic s);
		tick(3);
		sda_drv <= b;
		tick(3);
		scl <= 1'b1;
		tick(2);
		s = sda_line;
		scl <= 1'b0;
	endtask
	task automatic start();
		tick(3);
		sda_drv <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		tick(3);
		sda_drv <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b1;
		tick(8);
	endtask
	// Released line reads high through the pull-up, so the ninth bit is 1
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~more, s);
	endtask
	// Start, nine clocks, start, stop
	task automatic recover();
		logic s;
		start();
		repeat (9) bit_io(1'b1, s);
		start();
		stop();
	endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the two-wire bus target front end
`timescale 1ns/1ns
module testbench;
	localparam int WCYC = 200;
	localparam logic [127:0] SNUM = 128'h3C5A96E10F1E2D3C4B5A69788796A5B4; // Arbitrary value
	localparam logic [2:0] STRAP = 3'h5;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wp = 1'b0;
	logic wr_ready = 1'b0;
	logic scl, sda_drv, sda_out, sda_oe_n, wr_valid, busy, standby, ack;
	logic [11:0] rd_addr, wr_addr;
	logic [7:0] wr_data, d;
	wire sda_line = sda_drv & (sda_oe_n | sda_out);
	wire [7:0] rd_data = rd_addr[7:0] ^ 8'hA5;
	int err_count = 0;
	int comparisons = 0;
	always #20 clock = ~clock;
	sebfe_host i_host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	sebfe_target #(.WRITE_CYCLES(WCYC), .SERIAL_NUMBER(SNUM)) i_dut (.clock(clock), .rst(rst),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.strap_addr_bit2(STRAP[2]), .strap_addr_bit1(STRAP[1]), .strap_addr_bit0(STRAP[0]),
		.write_protect(wp), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy), .standby(standby));
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One-edge pulse on ready so exactly one word leaves the buffer
	task automatic take();
		@(posedge clock);
		wr_ready <= 1'b1;
		@(posedge clock);
		wr_ready <= 1'b0;
		repeat (2) @(negedge clock);
	endtask
	task automatic t_write();
		i_host.start();
		i_host.send({4'hA, STRAP, 1'b0}, ack);
		chk("device ack", 1, ack);
		i_host.send(8'hF3, ack);
		i_host.send(8'h1F, ack);
		i_host.send(8'h5A, ack);
		i_host.send(8'hA5, ack);
		chk("data ack", 1, ack);
		i_host.send(8'h3C, ack);
		chk("full buffer ack", 0, ack);
		i_host.stop();
		chk("head addr", 12'h31F, wr_addr);
		chk("head data", 8'h5A, wr_data);
		take();
		chk("wrapped addr", 12'h300, wr_addr);
		chk("second data", 8'hA5, wr_data);
		take();
		chk("buffer empty", 0, wr_valid);
		chk("busy", 1, busy);
		i_host.start();
		i_host.send({4'hA, STRAP, 1'b1}, ack);
		chk("poll ack", 0, ack);
		i_host.stop();
		for (int n = 0; n < 400 && busy !== 1'b0; n++)
			@(negedge clock);
		chk("busy end", 0, busy);
		if (busy !== 1'b0)
			report_and_stop();
		chk("standby", 1, standby);
		$display("write test done");
	endtask
	task automatic t_read(input logic [3:0] sel, input logic [7:0] wa1, input logic [7:0] wa2,
		input logic [7:0] e0, input logic [7:0] e1);
		i_host.start();
		i_host.send({sel, STRAP, 1'b0}, ack);
		i_host.send(wa1, ack);
		i_host.send(wa2, ack);
		i_host.start();
		i_host.send({sel, STRAP, 1'b1}, ack);
		chk("read ack", 1, ack);
		i_host.recv(1'b1, d);
		chk("first byte", e0, d);
		i_host.recv(1'b0, d);
		chk("next byte", e1, d);
		i_host.stop();
		chk("standby after read", 1, standby);
		$display("read test done");
	endtask
	task automatic t_refuse();
		i_host.start();
		i_host.send({4'hA, STRAP ^ 3'h1, 1'b1}, ack);
		chk("mismatch ack", 0, ack);
		i_host.stop();
		wp <= 1'b1;
		i_host.start();
		i_host.send({4'hA, STRAP, 1'b0}, ack);
		i_host.send(8'h00, ack);
		i_host.send(8'h00, ack);
		i_host.send(8'h77, ack);
		chk("protected ack", 1, ack);
		i_host.stop();
		chk("protected word", 0, wr_valid);
		chk("protected busy", 0, busy);
		wp <= 1'b0;
		i_host.start();
		i_host.send({4'hB, STRAP, 1'b0}, ack);
		i_host.send(8'h08, ack);
		i_host.send(8'h00, ack);
		i_host.send(8'h55, ack);
		chk("serial write ack", 1, ack);
		i_host.stop();
		chk("serial word", 0, wr_valid);
		chk("serial busy", 0, busy);
		$display("refusal test done");
	endtask
	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk("reset standby", 1, standby);
		chk("reset oe", 1, sda_oe_n);
		i_host.recover();
		t_write();
		t_read(4'hA, 8'h00, 8'h10, 8'h10 ^ 8'hA5, 8'h11 ^ 8'hA5);
		t_read(4'hB, 8'h08, 8'hEF, SNUM[7:0], 8'h00);
		t_read(4'hB, 8'h00, 8'hF0, 8'hFF, 8'hFF);
		t_refuse();
		report_and_stop();
	end
endmodule
